// [hw/recorder_consts.vh]
// Register map, field codes and timing constants of the disturbance recorder
`ifndef RECORDER_CONSTS_VH
`define RECORDER_CONSTS_VH

// Word index on the Avalon address bus; byte address is four times the index
`define REG_CTRL      4'h0
`define REG_STATUS    4'h1
`define REG_RATE      4'h2
`define REG_LEN       4'h3
`define REG_PRETRIGGER_SHARE   4'h4
`define REG_ROUTE     4'h5
`define REG_MANUAL    4'h6
`define REG_CHAN      4'h7
`define REG_MAX_LENGTH_LIMIT    4'h8
`define REG_READY     4'h9
`define REG_RDSEL     4'ha
`define REG_RDDATA    4'hb
`define REG_RDSTAMP   4'hc
`define REG_IRQ_STAT  4'hd
`define REG_IRQ_MASK  4'he

// Reset values
`define RST_RATE      4'h0
`define RST_LEN       16'h0100
`define RST_PRETRIGGER_SHARE   7'h14

// Reported status codes
`define ST_INACTIVE   2'h0
`define ST_ARMED      2'h1
`define ST_CAPTURE    2'h2
`define ST_FULL       2'h3

// Channel source codes: 0..11 measured, 8..11 of those calculated
`define CALC_FIRST    4'h8
`define SRC_BIN_IN    4'hc
`define SRC_BIN_OUT   4'hd
`define SRC_STARTS    4'he
`define SRC_TRIPS     4'hf

`define MAX_CH        4'hc
`define MAX_REC       4'hc
`define CALC_RATE_MIN 4'h4
`define RATE_LAST     4'hb
`define PCT_FULL      7'h64

// Sample periods per rate code, in microseconds
`define PER_0         26'h0000271
`define PER_1         26'h00004e2
`define PER_2         26'h00009c4
`define PER_3         26'h0002710
`define PER_4         26'h0004e20
`define PER_5         26'h0030d40
`define PER_6         26'h00f4240
`define PER_7         26'h04c4b40
`define PER_8         26'h0989680
`define PER_9         26'h0e4e1c0
`define PER_10        26'h1c9c380
`define PER_11        26'h3938700

// Time base
`define CLK_NS        32'h0000000a
`define US_NS         32'h000003e8
`define US_PER_S      42'h00000f4240

`endif

// [hw/sync3.v]
// Three-stage input synchroniser that updates a bit once stages two and three agree
module sync3 #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;

	always @(posedge clk) begin
		if (sys_rst) begin
			s1 <= {W{1'b0}};
			s2 <= {W{1'b0}};
			s3 <= {W{1'b0}};
			q  <= {W{1'b0}};
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= (s2 & s3) | (q & (s2 | s3));
		end
	end
endmodule

// [hw/disturbance_recorder.v]
// Disturbance recorder: triggered multi-channel capture into record memory
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`include "recorder_consts.vh"
module disturbance_recorder #(
	parameter MEM_WORDS = 4096,
	parameter AW        = 12,
	parameter US_CYCLES = `US_NS / `CLK_NS
) (
	input  wire         clk,
	input  wire         sys_rst,
	input  wire [3:0]   avs_address,
	input  wire         avs_read,
	input  wire         avs_write,
	input  wire [31:0]  avs_writedata,
	output reg  [31:0]  avs_readdata,
	output reg          avs_waitrequest,
	output reg          irq,
	output reg  [1:0]   recorder_state,
	input  wire [7:0]   binary_input_states,
	input  wire [1:0]   arc_states,
	input  wire [7:0]   binary_output_states,
	input  wire [7:0]   prot_start,
	input  wire [7:0]   prot_trip,
	input  wire [3:0]   logic_out,
	input  wire [3:0]   net_signal,
	input  wire [191:0] meas_data,
	input  wire [11:0]  meas_avail,
	input  wire [31:0]  timestamp_now
);
	localparam S_IDLE = 4'b0001;
	localparam S_ARM  = 4'b0010;
	localparam S_CAP  = 4'b0100;
	localparam S_FULL = 4'b1000;
	localparam [15:0] US_LAST = US_CYCLES[15:0] - 16'h1;

	reg         enable;
	reg         wrap;
	reg  [3:0]  rate;
	reg  [15:0] len;
	reg  [6:0]  pre_pct;
	reg  [31:0] route;
	reg  [3:0]  nch;
	reg  [3:0]  ch_src [0:11];
	reg         calc_in;
	reg  [3:0]  state;
	reg  [3:0]  n_rec;
	reg  [3:0]  oldest;
	reg  [31:0] stamp [0:11];
	reg  [15:0] start_idx [0:11];
	reg  [15:0] mem [0:MEM_WORDS-1];
	reg  [15:0] sidx;
	reg  [15:0] filled;
	reg  [15:0] post_left;
	reg         burst;
	reg  [3:0]  bch;
	reg  [15:0] us_div;
	reg  [25:0] us_cnt;
	reg  [31:0] src_prev;
	reg         trig_pend;
	reg  [2:0]  irq_stat;
	reg  [2:0]  irq_mask;
	reg  [3:0]  rd_sel;
	reg  [15:0] rd_smp;
	reg  [3:0]  rd_ch;
	reg  [25:0] per_now;
	reg  [3:0]  m_max;
	reg  [15:0] cval;
	reg  [31:0] rmux;
	integer     k;

	wire [9:0] in_sync;

	sync3 #(.W(10)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({arc_states, binary_input_states}),
		.q       (in_sync)
	);

	function [3:0] wrap4;
		input [3:0] a;
		input [3:0] b;
		input [3:0] m;
		reg   [4:0] s;
		begin
			s = {1'b0, a} + {1'b0, b};
			wrap4 = (s >= {1'b0, m}) ? (s[3:0] - m) : s[3:0];
		end
	endfunction

	// Bus handshake
	wire req  = avs_read | avs_write;
	wire acc  = req & ~avs_waitrequest;
	wire wr   = acc & avs_write;
	wire rd   = acc & avs_read;
	wire [31:0] wd = avs_writedata;
	wire idle = (state == S_IDLE);

	always @* begin
		case (rate)
			4'h0: per_now = `PER_0;
			4'h1: per_now = `PER_1;
			4'h2: per_now = `PER_2;
			4'h3: per_now = `PER_3;
			4'h4: per_now = `PER_4;
			4'h5: per_now = `PER_5;
			4'h6: per_now = `PER_6;
			4'h7: per_now = `PER_7;
			4'h8: per_now = `PER_8;
			4'h9: per_now = `PER_9;
			4'ha: per_now = `PER_10;
			default: per_now = `PER_11;
		endcase
	end

	// Words per record and how many records fit, never above twelve
	wire [19:0] wpr = nch * len;

	always @* begin
		m_max = 4'h0;
		for (k = 1; k <= `MAX_REC; k = k + 1) begin
			if (nch != 4'h0 && k * wpr <= MEM_WORDS)
				m_max = k[3:0];
		end
	end

	// Longest record the memory holds, in whole seconds
	wire [31:0] pcw     = (nch == 4'h0) ? 32'h0 : MEM_WORDS / nch;
	wire [41:0] len_us  = pcw[15:0] * per_now;
	wire [41:0] len_s   = len_us / `US_PER_S;

	// Write slot, sample address and channel value
	wire [3:0]  wslot   = wrap4(oldest, n_rec, m_max);
	wire [23:0] wa_full = wslot * wpr + sidx * nch + bch;

	always @* begin
		case (ch_src[bch])
			`SRC_BIN_IN:  cval = {6'h0, in_sync};
			`SRC_BIN_OUT: cval = {8'h0, binary_output_states};
			`SRC_STARTS:  cval = {8'h0, prot_start};
			`SRC_TRIPS:   cval = {8'h0, prot_trip};
			default:      cval = meas_data[ch_src[bch] * 16 +: 16];
		endcase
	end

	// Read-out address: selected record, sample order from its start
	wire [3:0]  rslot   = wrap4(oldest, rd_sel, m_max);
	wire [16:0] rs_sum  = start_idx[rslot] + rd_smp;
	wire [15:0] rs_idx  = (rs_sum >= {1'b0, len}) ? (rs_sum[15:0] - len) : rs_sum[15:0];
	wire [23:0] ra_full = rslot * wpr + rs_idx * nch + rd_ch;

	// Pre-trigger share, at least the trigger sample follows
	wire [22:0] pre_prod = len * pre_pct;
	wire [22:0] pre_q    = pre_prod / `PCT_FULL;
	wire [15:0] pre_len  = (pre_q[15:0] >= len) ? (len - 16'h1) : pre_q[15:0];
	wire [15:0] pre_av   = (filled < pre_len) ? filled : pre_len;
	wire [15:0] st_idx   = (sidx >= pre_av) ? (sidx - pre_av) : (sidx + len - pre_av);

	// Trigger sources and events
	wire [31:0] src_vec  = {net_signal, logic_out, in_sync[7:0], prot_trip, prot_start};
	wire auto_trig = |(src_vec & ~src_prev & route);
	wire man_trig  = wr && avs_address == `REG_MANUAL && wd[0];
	wire trig_now  = auto_trig | man_trig | trig_pend;

	wire tick      = (us_div == US_LAST) && (us_cnt >= per_now - 26'h1);
	wire burst_end = burst && (bch == nch - 4'h1);

	wire [3:0]  code     = wd[3:0];
	wire [15:0] avail_v  = {4'hf, meas_avail};
	wire is_calc   = code >= `CALC_FIRST && code < `SRC_BIN_IN;
	wire reject    = !avail_v[code] || (is_calc && rate < `CALC_RATE_MIN);
	wire add_cmd   = wr && idle && avs_address == `REG_CHAN && !wd[4];
	wire add_room  = nch < `MAX_CH;
	wire ev_drop   = add_cmd && add_room && reject;
	wire ev_done   = state == S_CAP && burst_end && post_left == 16'h1;
	wire ev_refuse = state == S_FULL && trig_now;
	wire cfg_wr    = wr && idle && (avs_address == `REG_LEN || avs_address == `REG_CHAN);
	wire clr_cmd   = wr && avs_address == `REG_CTRL && wd[2] && (idle || state == S_FULL);
	wire drop_cmd  = wr && avs_address == `REG_CTRL && wd[3] && (idle || state == S_FULL);

	always @* begin
		case (avs_address)
			`REG_CTRL:     rmux = {30'h0, wrap, enable};
			`REG_STATUS:   rmux = {30'h0, recorder_state};
			`REG_RATE:     rmux = {28'h0, rate};
			`REG_LEN:      rmux = {16'h0, len};
			`REG_PRETRIGGER_SHARE:  rmux = {25'h0, pre_pct};
			`REG_ROUTE:    rmux = route;
			`REG_CHAN:     rmux = {28'h0, nch};
			`REG_MAX_LENGTH_LIMIT:   rmux = len_s[31:0];
			`REG_READY:    rmux = {20'h0, m_max, 4'h0, n_rec};
			`REG_RDSEL:    rmux = {28'h0, rd_sel};
			`REG_RDDATA:   rmux = {16'h0, mem[ra_full[AW-1:0]]};
			`REG_RDSTAMP:  rmux = stamp[rslot];
			`REG_IRQ_STAT: rmux = {29'h0, irq_stat};
			`REG_IRQ_MASK: rmux = {29'h0, irq_mask};
			default:       rmux = 32'h0;
		endcase
	end

	always @(posedge clk) begin
		if (burst)
			mem[wa_full[AW-1:0]] <= cval;
	end

	always @(posedge clk) begin
		if (sys_rst) begin
			avs_readdata    <= 32'h0;
			avs_waitrequest <= 1'b1;
			irq             <= 1'b0;
			recorder_state  <= `ST_INACTIVE;
			enable          <= 1'b0;
			wrap            <= 1'b0;
			rate            <= `RST_RATE;
			len             <= `RST_LEN;
			pre_pct         <= `RST_PRETRIGGER_SHARE;
			route           <= 32'h0;
			nch             <= 4'h0;
			calc_in         <= 1'b0;
			state           <= S_IDLE;
			n_rec           <= 4'h0;
			oldest          <= 4'h0;
			sidx            <= 16'h0;
			filled          <= 16'h0;
			post_left       <= 16'h0;
			burst           <= 1'b0;
			bch             <= 4'h0;
			us_div          <= 16'h0;
			us_cnt          <= 26'h0;
			src_prev        <= 32'h0;
			trig_pend       <= 1'b0;
			irq_stat        <= 3'h0;
			irq_mask        <= 3'h0;
			rd_sel          <= 4'h0;
			rd_smp          <= 16'h0;
			rd_ch           <= 4'h0;
		end else begin
			if (req && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= rmux;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			irq <= |(irq_stat & irq_mask);
			case (state)
				S_ARM:   recorder_state <= `ST_ARMED;
				S_CAP:   recorder_state <= `ST_CAPTURE;
				S_FULL:  recorder_state <= `ST_FULL;
				default: recorder_state <= `ST_INACTIVE;
			endcase
			src_prev  <= src_vec;
			trig_pend <= (state == S_ARM) && burst_end && trig_now;
			// Set wins over a write-one clear in the same cycle
			irq_stat  <= (irq_stat & ~(wr && avs_address == `REG_IRQ_STAT ? wd[2:0] : 3'h0))
				| {ev_drop, ev_refuse, ev_done};

			// Microsecond time base paced by the selected rate
			if (us_div == US_LAST) begin
				us_div <= 16'h0;
				us_cnt <= tick ? 26'h0 : us_cnt + 26'h1;
			end else begin
				us_div <= us_div + 16'h1;
			end

			if (wr) begin
				case (avs_address)
					`REG_CTRL: begin
						enable <= wd[0];
						wrap   <= wd[1];
					end
					`REG_RATE:
						if (idle && wd[3:0] <= `RATE_LAST &&
							!(calc_in && wd[3:0] < `CALC_RATE_MIN))
							rate <= wd[3:0];
					`REG_LEN:
						if (idle && wd[15:0] != 16'h0)
							len <= wd[15:0];
					`REG_PRETRIGGER_SHARE:
						if (idle)
							pre_pct <= (wd[6:0] > `PCT_FULL) ? `PCT_FULL : wd[6:0];
					`REG_ROUTE:    route <= wd;
					`REG_IRQ_MASK: irq_mask <= wd[2:0];
					`REG_RDSEL: begin
						rd_sel <= wd[3:0];
						rd_smp <= 16'h0;
						rd_ch  <= 4'h0;
					end
					`REG_CHAN:
						if (idle && wd[4]) begin
							nch     <= 4'h0;
							calc_in <= 1'b0;
						end else if (add_cmd && add_room && !reject) begin
							ch_src[nch] <= code;
							nch         <= nch + 4'h1;
							calc_in     <= calc_in | is_calc;
						end
					default: ;
				endcase
			end

			// Reading a data word steps channel, then sample
			if (rd && avs_address == `REG_RDDATA) begin
				if (rd_ch >= nch - 4'h1) begin
					rd_ch  <= 4'h0;
					rd_smp <= rd_smp + 16'h1;
				end else begin
					rd_ch <= rd_ch + 4'h1;
				end
			end

			// Sample burst: one word per channel into the current slot
			if (burst) begin
				bch <= bch + 4'h1;
				if (burst_end) begin
					burst  <= 1'b0;
					bch    <= 4'h0;
					sidx   <= (sidx == len - 16'h1) ? 16'h0 : sidx + 16'h1;
					filled <= (filled == len) ? len : filled + 16'h1;
					if (state == S_CAP)
						post_left <= post_left - 16'h1;
				end
			end else if (tick && (state == S_ARM || state == S_CAP)) begin
				burst <= 1'b1;
				bch   <= 4'h0;
			end

			if (cfg_wr || clr_cmd) begin
				n_rec  <= 4'h0;
				oldest <= 4'h0;
			end else if (drop_cmd && n_rec != 4'h0) begin
				n_rec  <= n_rec - 4'h1;
				oldest <= wrap4(oldest, 4'h1, m_max);
			end

			case (state)
				S_IDLE:
					if (enable && m_max != 4'h0) begin
						state  <= S_ARM;
						sidx   <= 16'h0;
						filled <= 16'h0;
					end
				S_ARM:
					if (!enable) begin
						state <= S_IDLE;
					end else if (n_rec >= m_max) begin
						if (wrap) begin
							n_rec  <= n_rec - 4'h1;
							oldest <= wrap4(oldest, 4'h1, m_max);
						end else begin
							state <= S_FULL;
						end
					end else if (trig_now && !burst_end) begin
						stamp[wslot]     <= timestamp_now;
						start_idx[wslot] <= st_idx;
						post_left        <= len - pre_av;
						state            <= S_CAP;
					end
				S_CAP:
					if (!enable) begin
						state <= S_IDLE;
					end else if (ev_done) begin
						n_rec  <= n_rec + 4'h1;
						state  <= S_ARM;
						sidx   <= 16'h0;
						filled <= 16'h0;
					end
				S_FULL:
					if (!enable) begin
						state <= S_IDLE;
					end else if (n_rec < m_max || wrap) begin
						state  <= S_ARM;
						sidx   <= 16'h0;
						filled <= 16'h0;
					end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

// [dv/recorder_monitor.sv]
// Port-level assertions for the disturbance recorder
`include "recorder_consts.vh"
module recorder_monitor (
	input wire        clk,
	input wire        sys_rst,
	input wire [3:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	input wire [1:0]  recorder_state
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire rd_ack = avs_read && !avs_waitrequest;
	wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == `REG_CTRL;

	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer late");
	property p_wait_short;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_short: assert property (p_wait_short) else $error("wait low too long");
	property p_ack_cause;
		!avs_waitrequest |-> $past(avs_read || avs_write);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
	property p_idle_hold;
		recorder_state == `ST_INACTIVE && !ctrl_wr && !$past(ctrl_wr) && !$past(ctrl_wr, 2)
			|=> recorder_state == `ST_INACTIVE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("left inactive");
	property p_full_hold;
		recorder_state == `ST_FULL && !ctrl_wr && !$past(ctrl_wr) && !$past(ctrl_wr, 2)
			|=> recorder_state == `ST_FULL;
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("left full state");
	property p_manual_go;
		recorder_state == `ST_ARMED && avs_write && !avs_waitrequest
			&& avs_address == `REG_MANUAL && avs_writedata[0] |-> ##[1:3] recorder_state == `ST_CAPTURE;
	endproperty
	a_manual_go: assert property (p_manual_go) else $error("manual capture lost");
	property p_pct_clamp;
		rd_ack && avs_address == `REG_PRETRIGGER_SHARE |-> avs_readdata <= 32'h00000064;
	endproperty
	a_pct_clamp: assert property (p_pct_clamp) else $error("share above full");
	property p_chan_cap;
		rd_ack && avs_address == `REG_CHAN |-> avs_readdata <= 32'h0000000c;
	endproperty
	a_chan_cap: assert property (p_chan_cap) else $error("too many channels");
	property p_ready_cap;
		rd_ack && avs_address == `REG_READY |-> avs_readdata[3:0] <= avs_readdata[11:8]
			&& avs_readdata[11:8] <= 4'hc && avs_readdata[31:12] == 20'h0;
	endproperty
	a_ready_cap: assert property (p_ready_cap) else $error("record count bad");
	property p_rate_range;
		rd_ack && avs_address == `REG_RATE |-> avs_readdata <= 32'h0000000b;
	endproperty
	a_rate_range: assert property (p_rate_range) else $error("rate code bad");
	property p_unmapped;
		rd_ack && avs_address == 4'hf |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind disturbance_recorder recorder_monitor u_mon (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .recorder_state(recorder_state));

// [dv/recorder_sources.sv]
// Trigger sources, measurements and system time seen by the recorder
module recorder_sources (
	input  wire        clk,
	input  wire        fire,
	input  wire [2:0]  fire_sel,
	input  wire [11:0] avail,
	output logic [7:0]   binary_input_states,
	output logic [1:0]   arc_states,
	output logic [7:0]   binary_output_states,
	output logic [7:0]   prot_start,
	output logic [7:0]   prot_trip,
	output logic [3:0]   logic_out,
	output logic [3:0]   net_signal,
	output logic [191:0] meas_data,
	output logic [11:0]  meas_avail,
	output logic [31:0]  timestamp_now
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold = 4'h0;
	logic [2:0] sel = 3'h0;
	wire        act = hold != 4'h0;
	initial timestamp_now = 32'h0;
	// Pulse stands long enough to pass the input synchroniser
	always @(posedge clk) begin
		timestamp_now <= timestamp_now + 32'h1;
		if (fire) begin
			hold <= 4'h8;
			sel <= fire_sel;
		end else if (act) begin
			hold <= hold - 4'h1;
		end
	end
	always @* begin
		prot_start = {7'h0, act && sel == 3'h0};
		prot_trip = {7'h0, act && sel == 3'h1};
		binary_input_states = {7'h0, act && sel == 3'h2};
		logic_out = {3'h0, act && sel == 3'h3};
		net_signal = {3'h0, act && sel == 3'h4};
		arc_states = timestamp_now[9:8];
		binary_output_states = timestamp_now[7:0];
		meas_avail = avail;
		for (int c = 0; c < 12; c++) begin
			meas_data[16*c +: 16] = timestamp_now[15:0] + c[15:0];
		end
	end
endmodule

// [dv/disturbance_recorder_tb.sv]
// Register-level testbench of the disturbance recorder
`include "recorder_consts.vh"
module disturbance_recorder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  addr = 4'h0;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	wire  [31:0] rdata;
	wire         wait_req;
	wire         irq;
	wire  [1:0]  st;
	wire  [7:0]  din, dout, pst, ptr;
	wire  [3:0]  lout, nsig;
	wire  [1:0]  arc;
	wire  [191:0] meas;
	wire  [11:0] avail_o;
	wire  [31:0] now;
	logic        fire = 1'b0;
	logic [2:0]  fire_sel = 3'h0;
	logic [31:0] rd, s0, s1;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          route_bit [5] = '{0, 8, 16, 24, 28};
	int          codes [11] = '{0, 2, 3, 4, 5, 6, 7, 13, 14, 15, 8};

	always #5 clk = ~clk;

	disturbance_recorder #(.MEM_WORDS(64), .AW(6), .US_CYCLES(1)) u_dut (.clk(clk),
		.sys_rst(sys_rst), .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en),
		.avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_req), .irq(irq),
		.recorder_state(st), .binary_input_states(din), .arc_states(arc),
		.binary_output_states(dout), .prot_start(pst), .prot_trip(ptr), .logic_out(lout),
		.net_signal(nsig), .meas_data(meas), .meas_avail(avail_o), .timestamp_now(now));
	recorder_sources u_src (.clk(clk), .fire(fire), .fire_sel(fire_sel), .avail(12'hffd),
		.binary_input_states(din), .arc_states(arc), .binary_output_states(dout),
		.prot_start(pst), .prot_trip(ptr), .logic_out(lout), .net_signal(nsig),
		.meas_data(meas), .meas_avail(avail_o), .timestamp_now(now));

	task print_verdict;
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input [31:0] seen, input [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		int i;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= !w;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (wait_req !== 1'b0 && i < 20);
		rd = rdata;
		if (wait_req !== 1'b0) begin
			n_mismatch++;
			print_verdict;
		end
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask
	task wr(input [3:0] a, input [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input [3:0] a, input [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task wait_state(input [1:0] s, input int lim);
		for (int i = 0; i < lim && st !== s; i++) @(posedge clk);
		if (st !== s) begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	task capture(input [1:0] after_s);
		wait_state(`ST_CAPTURE, 12);
		wait_state(after_s, 3000);
	endtask
	task fire_src(input int s);
		@(posedge clk);
		fire_sel <= s[2:0];
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
	endtask

	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rdc(`REG_STATUS, 32'h0);
		rdc(`REG_RATE, 32'h0);
		rdc(`REG_LEN, 32'h100);
		rdc(`REG_PRETRIGGER_SHARE, 32'h14);
		rdc(4'hf, 32'h0);
		wr(`REG_PRETRIGGER_SHARE, 32'h7f);
		rdc(`REG_PRETRIGGER_SHARE, 32'h64);
		wr(`REG_CHAN, 32'h8);
		rdc(`REG_CHAN, 32'h0);
		rdc(`REG_IRQ_STAT, 32'h4);
		wr(`REG_IRQ_MASK, 32'h4);
		rdc(`REG_IRQ_MASK, 32'h4);
		check(irq, 32'h1);
		wr(`REG_IRQ_STAT, 32'h4);
		rdc(`REG_IRQ_STAT, 32'h0);
		check(irq, 32'h0);
		wr(`REG_CHAN, 32'h1);
		rdc(`REG_CHAN, 32'h0);
		wr(`REG_RATE, 32'hc);
		rdc(`REG_RATE, 32'h0);
		wr(`REG_RATE, 32'h4);
		wr(`REG_CHAN, 32'hc);
		rdc(`REG_CHAN, 32'h1);
		foreach (codes[i]) wr(`REG_CHAN, codes[i]);
		rdc(`REG_CHAN, 32'hc);
		wr(`REG_CHAN, 32'h9);
		rdc(`REG_CHAN, 32'hc);
		wr(`REG_CHAN, 32'h10);
		wr(`REG_CHAN, 32'hc);
		wr(`REG_RATE, 32'hb);
		rdc(`REG_MAX_LENGTH_LIMIT, 32'hf00);
		wr(`REG_RATE, 32'h0);
		wr(`REG_LEN, 32'h2);
		rdc(`REG_READY, 32'hc00);
		wr(`REG_IRQ_STAT, 32'h7);
		wr(`REG_CTRL, 32'h1);
		wait_state(`ST_ARMED, 4);
		for (int k = 0; k < 5; k++) begin
			wr(`REG_ROUTE, 32'h1 << route_bit[k]);
			fire_src(k);
			capture(`ST_ARMED);
		end
		wr(`REG_ROUTE, 32'h0);
		fire_src(0);
		repeat (20) @(posedge clk);
		check(st, `ST_ARMED);
		rdc(`REG_READY, 32'hc05);
		for (int k = 0; k < 7; k++) begin
			wr(`REG_MANUAL, 32'h1);
			capture(k == 6 ? `ST_FULL : `ST_ARMED);
		end
		rdc(`REG_READY, 32'hc0c);
		wr(`REG_MANUAL, 32'h1);
		repeat (4) @(posedge clk);
		check(st, `ST_FULL);
		rdc(`REG_IRQ_STAT, 32'h3);
		wr(`REG_RDSEL, 32'h0);
		bus(1'b0, `REG_RDSTAMP, 32'h0);
		s0 = rd;
		wr(`REG_RDSEL, 32'h1);
		bus(1'b0, `REG_RDSTAMP, 32'h0);
		s1 = rd;
		check({31'h0, s1 > s0}, 32'h1);
		wr(`REG_RDSEL, 32'h2);
		bus(1'b0, `REG_RDSTAMP, 32'h0);
		s0 = rd;
		// Wrap mode frees the oldest slot on arming, so eleven stay readable
		wr(`REG_CTRL, 32'h3);
		wait_state(`ST_ARMED, 8);
		rdc(`REG_READY, 32'hc0b);
		wr(`REG_MANUAL, 32'h1);
		capture(`ST_ARMED);
		rdc(`REG_READY, 32'hc0b);
		wr(`REG_RDSEL, 32'h0);
		rdc(`REG_RDSTAMP, s0);
		wr(`REG_RDSEL, 32'ha);
		bus(1'b0, `REG_RDSTAMP, 32'h0);
		check({31'h0, rd > s0}, 32'h1);
		print_verdict;
	end

	initial begin
		#1000000;
		n_mismatch++;
		print_verdict;
	end
endmodule
